// ===== verilog/alsr_top.sv
// alsr_top: link rate masks, port counters and statistics query answer
// assumes: event inputs are single-cycle pulses from logic on aclk;
// query parser and frame sender outside handle header and framing
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R01: active rate byte one-hot only when alternate fabric and link up, else zero
// R02: supported rate byte sets one bit per supported rate, SDR bit 0
// R03: ethernet link type reports zero supported rates
// R04: controller sends query code 0x39 with header, checksum and pad
// R05: query support needed only where alternate fabric is implemented
// R06: good query accepted when idle, answered with response code 0xb9
// R07: answer holds codes, counters in fixed order, then 32-bit checksum
// R08: unimplemented counters answer as all ones
// R09: counters clear only on reset; reads leave them alone
// R10: octet counters count data octets over all lanes divided by four
// R11: packet counters count every packet, errored ones included
// R12: stall ticks count ticks with data pending and nothing sent
// R13: drop counter counts outbound packets dropped, port down or congested
// R14: minor lane errors counted once per event across lanes
// R15: successful link error recoveries counted
// R16: failed recoveries that take the link down counted
// R17: received packets containing errors counted
// R18: received packets ending in bad-packet delimiter counted
// R19: received packets the relay cannot forward counted
// R20: integrity count rises when local physical errors exceed threshold
// R21: overrun count rises after threshold consecutive periods with overrun
// R22: management lane packets dropped for lack of resources counted
// R23: link type bit 0 picks ethernet (0) or alternate fabric (1)
// R24: multi-byte fields leave most significant byte first
module alsr_top
    import alsr_pkg::*;
#(
    parameter int unsigned ADDR_W = 8,
    parameter logic [NUM_COUNTERS-1:0] COUNTER_IMPL = 15'h7fff,
    parameter logic ALT_FABRIC_CAPABLE = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic query_valid,
    input wire logic [7:0] query_cmd,
    input wire logic query_bad,
    output logic query_ready,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic resp_last,
    input wire logic resp_ready,
    input wire logic phys_link_up,
    input wire logic [2:0] active_rate_index,
    output logic [7:0] active_rate_mask,
    output logic [7:0] supported_rate_mask,
    input wire logic [7:0] tx_octets,
    input wire logic [7:0] rx_octets,
    input wire logic tx_packet,
    input wire logic rx_packet,
    input wire logic tx_tick,
    input wire logic tx_pending,
    input wire logic tx_sent,
    input wire logic tx_drop,
    input wire logic lane_minor_error,
    input wire logic recovery_ok,
    input wire logic recovery_fail,
    input wire logic rx_bad_packet,
    input wire logic rx_ebp_packet,
    input wire logic rx_unforwardable,
    input wire logic local_phy_error,
    input wire logic fc_period_end,
    input wire logic overrun_error,
    input wire logic mgmt_lane_drop
);

    function automatic logic [7:0] word_byte(input logic [31:0] w,
                                             input logic [1:0] lane);
        case (lane)
            2'h0: word_byte = w[31:24];
            2'h1: word_byte = w[23:16];
            2'h2: word_byte = w[15:8];
            default: word_byte = w[7:0];
        endcase
    endfunction : word_byte

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] off);
        logic [ADDR_W-1:0] o;
        o = ADDR_W'(off);
        addr_is = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
    endfunction : addr_is

    function automatic logic [7:0] put_byte(input logic [7:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] strb,
                                            input logic [1:0] lane);
        put_byte = strb[lane] ? d[8*lane +: 8] : old;
    endfunction : put_byte

    alsr_state_t state;
    logic [7:0] link_type_cfg;
    logic [7:0] rate_support_cfg;
    logic [7:0] phy_error_threshold;
    logic [7:0] overrun_period_threshold;
    logic [31:0] query_count;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [31:0] next_rdata;
    logic alt_mode;
    logic [ACC_W-1:0] acc [NUM_COUNTERS];
    logic [ACC_W-1:0] amt [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] ev_inc;
    logic tick_all_pend;
    logic tick_any_sent;
    logic stall_hit;
    logic [7:0] phy_err_run;
    logic integ_hit;
    logic ovr_in_period;
    logic [7:0] ovr_run;
    logic period_bad;
    logic ovr_hit;
    logic [31:0] view [FRAME_WORDS];
    logic [31:0] snap [FRAME_WORDS];
    logic [31:0] csum_sum;
    logic [31:0] next_csum;
    logic [31:0] csum_q;
    logic [6:0] frame_idx;
    logic [6:0] next_idx;
    logic start;
    logic resp_fire;
    logic unimpl_ok;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // R23 link type from bit 0
    assign alt_mode = link_type_cfg[LINK_TYPE_ALT_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_rate_mask <= 8'h00;
            supported_rate_mask <= 8'h00;
        end else if (ce) begin
            // R01 one-hot only while up
            active_rate_mask <= (alt_mode && phys_link_up) ?
                                8'(8'h01 << active_rate_index) : 8'h00;
            // R02 R03 supported rates
            supported_rate_mask <= alt_mode ? rate_support_cfg : 8'h00;
        end
    end

    a_active_gate: assert property ((ce && !(alt_mode && phys_link_up))
        |=> active_rate_mask == 8'h00) else $error("active mask not zero"); // R01
    a_active_onehot: assert property ((ce && alt_mode && phys_link_up)
        |=> active_rate_mask == 8'(8'h01 << $past(active_rate_index)))
        else $error("active mask wrong rate"); // R01
    a_supported_copy: assert property ((ce && alt_mode)
        |=> supported_rate_mask == $past(rate_support_cfg))
        else $error("supported mask wrong"); // R02
    a_supported_eth: assert property ((ce && !alt_mode)
        |=> supported_rate_mask == 8'h00)
        else $error("ethernet supported mask not zero"); // R03

    // R12 tick tracking
    assign stall_hit = tx_tick && tick_all_pend && tx_pending
                       && !tick_any_sent && !tx_sent;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_all_pend <= 1'b0;
            tick_any_sent <= 1'b0;
        end else if (ce) begin
            tick_all_pend <= tx_tick ? 1'b1 : (tick_all_pend && tx_pending);
            tick_any_sent <= tx_tick ? 1'b0 : (tick_any_sent || tx_sent);
        end
    end

    // R20 threshold exceeded
    assign integ_hit = local_phy_error &&
                       (phy_err_run >= phy_error_threshold);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_err_run <= 8'h00;
        end else if (ce && local_phy_error) begin
            phy_err_run <= integ_hit ? 8'h00 : 8'(phy_err_run + 8'h01);
        end
    end

    // R21 consecutive bad periods
    assign period_bad = ovr_in_period || overrun_error;
    assign ovr_hit = fc_period_end && period_bad &&
                     (8'(ovr_run + 8'h01) >= overrun_period_threshold);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr_in_period <= 1'b0;
            ovr_run <= 8'h00;
        end else if (ce) begin
            ovr_in_period <= fc_period_end ? 1'b0 :
                             (ovr_in_period || overrun_error);
            if (fc_period_end) begin
                ovr_run <= (period_bad && !ovr_hit) ?
                           8'(ovr_run + 8'h01) : 8'h00;
            end
        end
    end

    // R11 R13 R14 R15 R16 R17 R18 R19 R22 event slots
    assign ev_inc = {mgmt_lane_drop, ovr_hit, integ_hit, rx_unforwardable,
                     rx_ebp_packet, rx_bad_packet, recovery_fail,
                     recovery_ok, lane_minor_error, tx_drop, stall_hit,
                     rx_packet, tx_packet, 2'b00};

    // R10 events kept times four, octets kept raw, quads read above bit 1
    always_comb begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            amt[i] = {31'h0, ev_inc[i], 2'b00};
        end
        amt[IDX_TX_OCTET_QUADS] = {26'h0, tx_octets};
        amt[IDX_RX_OCTET_QUADS] = {26'h0, rx_octets};
    end

    // R09 cleared by reset only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                acc[i] <= 34'h0;
            end
        end else if (ce) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                acc[i] <= acc[i] + amt[i];
            end
        end
    end

    a_count_hold: assert property ((ce && !tx_drop)
        |=> $stable(acc[IDX_TX_DROP_COUNT]))
        else $error("drop counter moved without event"); // R09
    a_octet_sum: assert property (ce |=> acc[IDX_TX_OCTET_QUADS] ==
        $past(acc[IDX_TX_OCTET_QUADS]) + {26'h0, $past(tx_octets)})
        else $error("octet sum wrong"); // R10
    a_stall_tick: assert property ((ce && tx_tick && !tx_pending)
        |=> $stable(acc[IDX_TX_STALL_TICKS]))
        else $error("stall counted without pending"); // R12

    // R06 R08 answer words
    always_comb begin
        view[0] = {RESP_CODE_STATS, REASON_NONE};
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            view[i + 1] = COUNTER_IMPL[i] ? acc[i][ACC_W-1:2] : UNIMPL_VALUE;
        end
    end

    // R07 checksum over codes and counters
    always_comb begin
        csum_sum = 32'h0;
        for (int i = 0; i < FRAME_WORDS; i++) begin
            csum_sum = csum_sum + {16'h0, view[i][31:16]}
                                + {16'h0, view[i][15:0]};
        end
        next_csum = (~csum_sum) + 32'h1;
    end

    // R05 R06 good query starts the answer
    assign start = ce && query_valid && query_ready && ALT_FABRIC_CAPABLE
                   && (query_cmd == CMD_STATS_QUERY) && !query_bad;
    assign resp_fire = ce && resp_valid && resp_ready;
    assign next_idx = 7'(frame_idx + 7'h01);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < FRAME_WORDS; i++) begin
                snap[i] <= 32'h0;
            end
            csum_q <= 32'h0;
        end else if (start) begin
            snap <= view;
            csum_q <= next_csum;
        end
    end

    // R24 most significant byte first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ALSR_IDLE;
            query_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= 8'h00;
            resp_last <= 1'b0;
            frame_idx <= 7'h00;
            query_count <= 32'h0;
        end else if (ce) begin
            case (state)
                ALSR_IDLE: begin
                    query_ready <= 1'b1;
                    if (start) begin
                        state <= ALSR_SEND;
                        query_ready <= 1'b0;
                        resp_valid <= 1'b1;
                        resp_data <= word_byte(view[0], 2'h0);
                        resp_last <= 1'b0;
                        frame_idx <= 7'h00;
                    end
                end
                ALSR_SEND: begin
                    if (resp_fire) begin
                        if (frame_idx == LAST_IDX) begin
                            state <= ALSR_IDLE;
                            query_ready <= 1'b1;
                            resp_valid <= 1'b0;
                            resp_last <= 1'b0;
                            query_count <= query_count + 32'h1;
                        end else begin
                            frame_idx <= next_idx;
                            resp_last <= (next_idx == LAST_IDX);
                            resp_data <= (next_idx < CSUM_IDX) ?
                                word_byte(snap[next_idx[5:2]], next_idx[1:0])
                                : word_byte(csum_q, next_idx[1:0]);
                        end
                    end
                end
                default: begin
                    state <= ALSR_IDLE;
                    resp_valid <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        unimpl_ok = 1'b1;
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            if (!COUNTER_IMPL[i] && snap[i + 1] != UNIMPL_VALUE) begin
                unimpl_ok = 1'b0;
            end
        end
    end

    a_query_answer: assert property (start |=> resp_valid && !query_ready
        && resp_data == RESP_CODE_STATS[15:8])
        else $error("query not answered"); // R06
    a_frame_length: assert property ((resp_fire && resp_last)
        |-> frame_idx == LAST_IDX)
        else $error("frame length wrong"); // R07
    a_unimpl_ones: assert property (start |=> unimpl_ok)
        else $error("unimplemented counter not all ones"); // R08
    a_word_msb: assert property ((resp_fire && frame_idx == 7'h03)
        |=> resp_data == snap[1][31:24])
        else $error("counter byte order wrong"); // R24
    a_busy_refuse: assert property ((state == ALSR_SEND)
        |-> !query_ready) else $error("query taken while busy"); // R06

    c_full_frame: cover property (resp_fire && resp_last);
    c_bad_query: cover property (ce && query_valid && query_ready
        && query_bad);
    c_stall: cover property (ce && stall_hit);
    c_integrity: cover property (ce && integ_hit);

    // AXI4-Lite write side
    assign wr_fire = ce && aw_got && w_got;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_got && w_got) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (addr_is(aw_addr_q, ADDR_LINK_CFG)
                    || addr_is(aw_addr_q, ADDR_RATE_CFG)
                    || addr_is(aw_addr_q, ADDR_THRESH)
                    || addr_is(aw_addr_q, ADDR_STATUS)
                    || addr_is(aw_addr_q, ADDR_QUERY_CNT)) ?
                    RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_type_cfg <= LINK_CFG_RST;
            rate_support_cfg <= RATE_CFG_RST;
            phy_error_threshold <= PHY_THR_RST;
            overrun_period_threshold <= OVR_THR_RST;
        end else if (wr_fire) begin
            if (addr_is(aw_addr_q, ADDR_LINK_CFG)) begin
                link_type_cfg <= put_byte(link_type_cfg, w_data_q,
                                          w_strb_q, 2'h0);
            end
            if (addr_is(aw_addr_q, ADDR_RATE_CFG)) begin
                rate_support_cfg <= put_byte(rate_support_cfg, w_data_q,
                                             w_strb_q, 2'h0);
            end
            if (addr_is(aw_addr_q, ADDR_THRESH)) begin
                phy_error_threshold <= put_byte(phy_error_threshold,
                                                w_data_q, w_strb_q, 2'h0);
                overrun_period_threshold <= put_byte(
                    overrun_period_threshold, w_data_q, w_strb_q, 2'h1);
            end
        end
    end

    // AXI4-Lite read side
    always_comb begin
        next_rdata = 32'h0;
        if (addr_is(s_axi_araddr, ADDR_LINK_CFG)) begin
            next_rdata = {24'h0, link_type_cfg};
        end else if (addr_is(s_axi_araddr, ADDR_RATE_CFG)) begin
            next_rdata = {24'h0, rate_support_cfg};
        end else if (addr_is(s_axi_araddr, ADDR_THRESH)) begin
            next_rdata = {16'h0, overrun_period_threshold,
                          phy_error_threshold};
        end else if (addr_is(s_axi_araddr, ADDR_STATUS)) begin
            next_rdata = {15'h0, (state == ALSR_SEND),
                          supported_rate_mask, active_rate_mask};
        end else if (addr_is(s_axi_araddr, ADDR_QUERY_CNT)) begin
            next_rdata = query_count;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= (addr_is(s_axi_araddr, ADDR_LINK_CFG)
                    || addr_is(s_axi_araddr, ADDR_RATE_CFG)
                    || addr_is(s_axi_araddr, ADDR_THRESH)
                    || addr_is(s_axi_araddr, ADDR_STATUS)
                    || addr_is(s_axi_araddr, ADDR_QUERY_CNT)) ?
                    RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : alsr_top

`default_nettype wire

// ===== verilog/alsr_pkg.sv
// alsr_pkg: constants for the alternate link statistics responder
// assumes: compiled before alsr_top, nothing else needed
`default_nettype none

package alsr_pkg;
    // query and response codes
    localparam logic [7:0] CMD_STATS_QUERY = 8'h39;
    localparam logic [15:0] RESP_CODE_STATS = 16'h00b9;
    localparam logic [15:0] REASON_NONE = 16'h0000;
    localparam logic [31:0] UNIMPL_VALUE = 32'hffffffff;

    // counter slots, in frame order
    localparam int unsigned NUM_COUNTERS = 15;
    localparam int unsigned IDX_TX_OCTET_QUADS = 0;
    localparam int unsigned IDX_RX_OCTET_QUADS = 1;
    localparam int unsigned IDX_TX_PACKET_COUNT = 2;
    localparam int unsigned IDX_TX_STALL_TICKS = 4;
    localparam int unsigned IDX_TX_DROP_COUNT = 5;
    localparam int unsigned ACC_W = 34;
    localparam int unsigned OCTET_LANES = 4;

    // frame layout: bytes 0..67 leave the block
    localparam int unsigned FRAME_WORDS = 16;
    localparam logic [6:0] CSUM_IDX = 7'h40;
    localparam logic [6:0] LAST_IDX = 7'h43;

    // link type field
    localparam int unsigned LINK_TYPE_ALT_BIT = 0;

    // register offsets
    localparam logic [7:0] ADDR_LINK_CFG = 8'h00;
    localparam logic [7:0] ADDR_RATE_CFG = 8'h04;
    localparam logic [7:0] ADDR_THRESH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_QUERY_CNT = 8'h10;

    // reset values
    localparam logic [7:0] LINK_CFG_RST = 8'h00;
    localparam logic [7:0] RATE_CFG_RST = 8'hff;
    localparam logic [7:0] PHY_THR_RST = 8'h08;
    localparam logic [7:0] OVR_THR_RST = 8'h04;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [0:0] {
        ALSR_IDLE = 1'b0,
        ALSR_SEND = 1'b1
    } alsr_state_t;
endpackage : alsr_pkg

`default_nettype wire

// ===== verif/alsr_mc_model.sv
// alsr_mc_model: controller end of the statistics query path
// assumes: bench pulses go for one cycle per query, after reset
`timescale 1ns/100ps
`default_nettype none
module alsr_mc_model (
    input wire logic aclk,
    input wire logic go,
    input wire logic [7:0] cmd,
    input wire logic bad,
    input wire logic query_ready,
    output logic query_valid,
    output logic [7:0] query_cmd,
    output logic query_bad,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    output logic resp_ready,
    output logic [7:0] frame [0:67],
    output int nbytes,
    input wire logic resp_last,
    output int last_pos
);
    initial begin
        query_valid = 1'b0;
        query_cmd = 8'h00;
        query_bad = 1'b0;
        resp_ready = 1'b0;
        nbytes = 0;
    end
    always @(posedge aclk) begin
        resp_ready <= ~resp_ready;
        if (go) begin
            query_valid <= 1'b1;
            query_cmd <= cmd;
            query_bad <= bad;
            nbytes <= 0;
            last_pos <= -1;
        end else if (query_valid && query_ready) begin
            query_valid <= 1'b0;
            query_cmd <= ~query_cmd;
            query_bad <= ~query_bad;
        end
        if (resp_valid && resp_ready && nbytes < 68) begin
            frame[nbytes] <= resp_data;
            nbytes <= nbytes + 1;
            if (resp_last && last_pos < 0) last_pos <= nbytes;
        end
    end
endmodule : alsr_mc_model
`default_nettype wire

// ===== verif/alt_link_stats_responder_bench.sv
// bench: rate masks, register access and statistics frames
// assumes: ce held high, one instance with the last counter unimplemented
`timescale 1ns/100ps
`default_nettype none
module alt_link_stats_responder_bench;
    import alsr_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] awa = 0, ara = 0, tx_o = 0, rx_o = 0, qc = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] bresp, rresp;
    logic awr, wr, bv, arr, rv, qv, qr, qb, rspv, rsprdy, go = 0, qbad = 0;
    logic [7:0] rspd, am, sm, qcm, frame [0:67];
    logic [2:0] ari = 0;
    logic up = 0, rl;
    logic [15:0] ev = 0;
    logic [31:0] exp_c [15] = '{32'd20, 32'd10, 32'd1, 32'd2, 32'd8, 32'd3,
        32'd4, 32'd5, 32'd6, 32'd7, 32'd8, 32'd9, 32'd1, 32'd2, UNIMPL_VALUE};
    int nb, lp, bad_count = 0, n_tests = 0;
    always #2 aclk = ~aclk;
    alsr_top #(.COUNTER_IMPL(15'h3fff)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .query_valid(qv),
        .query_cmd(qcm), .query_bad(qb), .query_ready(qr), .resp_valid(rspv),
        .resp_data(rspd), .resp_last(rl), .resp_ready(rsprdy),
        .phys_link_up(up), .active_rate_index(ari), .active_rate_mask(am),
        .supported_rate_mask(sm), .tx_octets(tx_o), .rx_octets(rx_o),
        .tx_packet(ev[0]), .rx_packet(ev[1]), .tx_drop(ev[2]),
        .lane_minor_error(ev[3]), .recovery_ok(ev[4]), .recovery_fail(ev[5]),
        .rx_bad_packet(ev[6]), .rx_ebp_packet(ev[7]),
        .rx_unforwardable(ev[8]), .mgmt_lane_drop(ev[9]), .tx_tick(ev[10]),
        .tx_pending(ev[11]), .tx_sent(ev[12]), .local_phy_error(ev[13]),
        .fc_period_end(ev[14]), .overrun_error(ev[15]));
    alsr_mc_model u_mc (.aclk(aclk), .go(go), .cmd(qc), .bad(qbad),
        .query_ready(qr), .query_valid(qv), .query_cmd(qcm), .query_bad(qb),
        .resp_valid(rspv), .resp_data(rspd), .resp_ready(rsprdy),
        .frame(frame), .nbytes(nb), .resp_last(rl), .last_pos(lp));
    task automatic test_done;
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic lim(input int n, input int m);
        if (n >= m) begin
            chk("wait", 0, 1);
            test_done();
        end
    endtask : lim
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (bv !== 1'b1 && n < 60);
        lim(n, 60);
        chk("bresp", {30'h0, e}, {30'h0, bresp});
        br <= 0;
        @(posedge aclk);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        ara <= a; arv <= 1; rr <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 0;
        end while (rv !== 1'b1 && n < 60);
        lim(n, 60);
        chk("rdata", e, rd);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rr <= 0;
        @(posedge aclk);
    endtask : axr
    task automatic query(input logic [7:0] c, input logic b, input int want);
        int n;
        logic [31:0] s;
        n = 0;
        s = 0;
        qc <= c; qbad <= b; go <= 1;
        @(posedge aclk);
        go <= 0;
        do begin
            @(posedge aclk);
            n++;
        end while (nb < want && n < 400);
        lim(n, 400);
        repeat (20) @(posedge aclk);
        chk("frame length", want, nb);
        if (want == 68) begin
            chk("last byte", 67, lp);
            chk("codes", {16'h00b9, 16'h0}, {frame[0], frame[1], frame[2], frame[3]});
            for (int i = 0; i < 15; i++) begin
                chk("counter", exp_c[i], {frame[4*i+4], frame[4*i+5], frame[4*i+6], frame[4*i+7]});
            end
            for (int i = 0; i < 32; i++) s += {frame[2*i], frame[2*i+1]};
            chk("checksum", -s, {frame[64], frame[65], frame[66], frame[67]});
        end
    endtask : query
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axr(ADDR_RATE_CFG, 32'h000000ff, RESP_OKAY);
        axr(ADDR_THRESH, 32'h00000408, RESP_OKAY);
        axr(8'h40, 32'h0, RESP_SLVERR);
        axw(8'h44, 32'h1, RESP_SLVERR);
        axw(ADDR_LINK_CFG, 32'hfe, RESP_OKAY);
        up <= 1;
        axr(ADDR_STATUS, 32'h0, RESP_OKAY);
        axw(ADDR_LINK_CFG, 32'h1, RESP_OKAY);
        axw(ADDR_RATE_CFG, 32'h35, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            ari <= i[2:0];
            repeat (3) @(posedge aclk);
            chk("active", 32'h1 << i, {24'h0, am});
            chk("supported", 32'h35, {24'h0, sm});
        end
        up <= 0;
        repeat (3) @(posedge aclk);
        chk("active down", 0, {24'h0, am});
        for (int i = 0; i < 10; i++) begin
            ev <= (16'h03ff & (16'h03ff << i)) | (i > 0 ? 16'hec00 : 16'h0);
            tx_o <= 8'h08;
            rx_o <= 8'h04;
            @(posedge aclk);
        end
        ev <= 0; tx_o <= 0; rx_o <= 0;
        query(8'h38, 1'b0, 0);
        query(CMD_STATS_QUERY, 1'b1, 0);
        query(CMD_STATS_QUERY, 1'b0, 68);
        query(CMD_STATS_QUERY, 1'b0, 68);
        axr(ADDR_QUERY_CNT, 32'h2, RESP_OKAY);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 14; i++) exp_c[i] = 0;
        query(CMD_STATS_QUERY, 1'b0, 68);
        test_done();
    end
endmodule : alt_link_stats_responder_bench
`default_nettype wire
